// ### rtl/sbcmc_top.sv
`include "sbcmc_params.svh"
module sbcmc_top #(
  parameter int unsigned OSC_TICK_CLKS = `SBC_OSC_TICK_CLKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial control port
  input wire logic serial_clk,
  input wire logic serial_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  // Transceiver logic side
  input wire logic can_txd,
  output logic can_rxd,
  input wire logic bus_dominant,
  output logic bus_drive_dominant,
  output logic low_line_termination,
  output logic high_line_termination,
  // Load switches
  input wire logic pwm_input,
  input wire logic wake_input,
  output logic high_switch_one,
  output logic high_switch_two,
  output logic high_switch_three,
  output logic low_switch_one,
  output logic low_switch_two,
  // Reset pin
  input wire logic reset_out_n_i,
  output logic reset_out_n,
  output logic reset_out_oe_n,
  // Status
  output sbcmc_pkg::sbcmc_mode_e current_mode,
  output sbcmc_pkg::sbcmc_cyc_e cyclic_state,
  output logic word_lost
);
  import sbcmc_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] pins;
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [7:0] sync_c;

  assign pins = {reset_out_n_i, bus_dominant, wake_input, pwm_input,
                 can_txd, serial_in, serial_select_n, serial_clk};

  // Reset levels mimic the pin pulls, so an open pin reads idle
  localparam logic [7:0] SYNC_RST = `SBC_SYNC_RESET;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync_a[gi] <= SYNC_RST[gi];
          sync_b[gi] <= SYNC_RST[gi];
          sync_c[gi] <= SYNC_RST[gi];
        end else begin
          sync_a[gi] <= pins[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate

  logic sclk_rise;
  logic sclk_fall;
  logic sel_q;
  logic sel_fall;
  logic sel_rise;
  logic si_q;
  logic txd_q;
  logic pwm_q;
  logic pwm_rise;
  logic wake_rise;
  logic bus_q;
  logic rst_pin_q;

  assign sclk_rise = sync_b[0] && !sync_c[0];
  assign sclk_fall = !sync_b[0] && sync_c[0];
  assign sel_q = !sync_b[1];
  // Select moves only with the clock low, so its edges never meet a clock edge
  assign sel_fall = !sync_b[1] && sync_c[1];
  assign sel_rise = sync_b[1] && !sync_c[1];
  assign si_q = sync_b[2];
  assign txd_q = sync_b[3];
  assign pwm_q = sync_b[4];
  assign pwm_rise = sync_b[4] && !sync_c[4];
  assign wake_rise = sync_b[5] && !sync_c[5];
  assign bus_q = sync_b[6];
  assign rst_pin_q = sync_b[7];

  // ----------------------------------------
  // Serial receive
  // ----------------------------------------
  sbcmc_word_t rx_shift;
  logic [4:0] bit_cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_shift <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (sel_fall) begin
      bit_cnt <= 5'h00;
    end else if (sel_q && sclk_fall) begin
      rx_shift <= {si_q, rx_shift[15:1]};
      if (bit_cnt != 5'h11) begin
        bit_cnt <= 5'(bit_cnt + 5'h01);
      end
    end
  end

  // ----------------------------------------
  // Word buffer
  // ----------------------------------------
  sbcmc_word_if word ();

  sbcmc_buf u_buf (
    .clk(clk),
    .rst(rst),
    .port(word.store)
  );

  logic apply;
  logic apply_hold;

  // A short or long frame is dropped and the settings stay
  assign word.push_valid = sel_rise && (bit_cnt == 5'h10);
  assign word.push_data = rx_shift;
  // One idle cycle after each apply lets the mode settle
  assign word.pop_ready = !apply_hold;
  assign apply = word.pop_valid && word.pop_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      apply_hold <= 1'b0;
    end else begin
      apply_hold <= apply;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_lost <= 1'b0;
    end else if (word.push_valid && !word.push_ready) begin
      word_lost <= 1'b1;
    end else if (sel_fall) begin
      word_lost <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control word and mode
  // ----------------------------------------
  sbcmc_word_t ctl;
  logic [1:0] next_bits;
  sbcmc_mode_e next_mode;

  function automatic sbcmc_mode_e decode_mode(input logic [1:0] bits);
    case (bits)
      `SBC_MODE_NORMAL: decode_mode = MODE_NORMAL;
      `SBC_MODE_CYCLIC: decode_mode = MODE_CYCLIC;
      `SBC_MODE_RXONLY: decode_mode = MODE_RXONLY;
      default: decode_mode = MODE_STANDBY;
    endcase
  endfunction

  assign next_bits = word.pop_data[`SBC_CTL_MODE_LSB +: 2];
  assign next_mode = decode_mode(next_bits);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl <= `SBC_CTL_RESET;
      current_mode <= MODE_STANDBY;
    end else if (apply) begin
      ctl <= word.pop_data;
      current_mode <= next_mode;
    end
  end

  // ----------------------------------------
  // Cyclic wake timer
  // ----------------------------------------
  logic [15:0] tick;
  logic [8:0] osc_cnt;
  logic [8:0] period;
  logic tick_wrap;
  logic timer_done;

  always_comb begin
    case (ctl[`SBC_CTL_PER_LSB +: 2])
      2'h0: period = `SBC_PERIOD_0;
      2'h1: period = `SBC_PERIOD_1;
      2'h2: period = `SBC_PERIOD_2;
      default: period = 9'h000;
    endcase
  end

  assign tick_wrap = (tick == 16'(OSC_TICK_CLKS - 1));
  assign timer_done = tick_wrap && (period != 9'h000) && (osc_cnt == 9'(period - 9'h001));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick <= 16'h0000;
      osc_cnt <= 9'h000;
    end else if (cyclic_state != CYC_HS_OFF) begin
      tick <= 16'h0000;
      osc_cnt <= 9'h000;
    end else if (tick_wrap) begin
      tick <= 16'h0000;
      osc_cnt <= 9'(osc_cnt + 9'h001);
    end else begin
      tick <= 16'(tick + 16'h0001);
    end
  end

  // ----------------------------------------
  // Cyclic wake substates
  // ----------------------------------------
  logic wake_seen;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyclic_state <= CYC_IDLE;
    end else if (apply) begin
      if (next_mode != MODE_CYCLIC) begin
        cyclic_state <= CYC_IDLE;
      end else if (current_mode != MODE_CYCLIC) begin
        cyclic_state <= CYC_HS_ON;
      end
    end else begin
      case (cyclic_state)
        CYC_HS_ON: begin
          if (pwm_rise) begin
            cyclic_state <= CYC_HS_OFF;
          end
        end
        CYC_HS_OFF: begin
          if (wake_rise || bus_q || timer_done) begin
            cyclic_state <= CYC_HS_ON;
          end
        end
        default: cyclic_state <= CYC_IDLE;
      endcase
    end
  end

  // Wake flag: a new edge in the capture cycle still counts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_seen <= 1'b0;
    end else if (wake_rise && cyclic_state == CYC_HS_OFF) begin
      wake_seen <= 1'b1;
    end else if (sel_fall) begin
      wake_seen <= 1'b0;
    end
  end

  // ----------------------------------------
  // Serial transmit
  // ----------------------------------------
  sbcmc_word_t diag;
  sbcmc_word_t tx_shift;

  always_comb begin
    diag = 16'h0000;
    diag[`SBC_DIAG_MODE_LSB +: 2] = current_mode;
    diag[`SBC_DIAG_HS_ON] = (cyclic_state == CYC_HS_ON);
    diag[`SBC_DIAG_WAKE] = wake_seen;
    diag[`SBC_DIAG_LOST] = word_lost;
    diag[`SBC_DIAG_RST_PIN] = rst_pin_q;
    diag[`SBC_DIAG_PWM] = pwm_q;
    diag[`SBC_DIAG_BUS] = bus_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_shift <= 16'h0000;
      serial_out <= 1'b0;
    end else if (sel_fall) begin
      tx_shift <= diag;
      serial_out <= diag[0];
    end else if (sel_q && sclk_rise) begin
      tx_shift <= {1'b0, tx_shift[15:1]};
      serial_out <= tx_shift[1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out_oe_n <= !sel_q;
    end
  end

  // ----------------------------------------
  // Transceiver control
  // ----------------------------------------
  logic rx_path_on;

  assign rx_path_on = (current_mode == MODE_NORMAL) || (current_mode == MODE_RXONLY);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_drive_dominant <= 1'b0;
      can_rxd <= 1'b1;
      low_line_termination <= 1'b1;
      high_line_termination <= 1'b1;
    end else begin
      bus_drive_dominant <= (current_mode == MODE_NORMAL) && !txd_q;
      if (current_mode == MODE_RXONLY && ctl[`SBC_CTL_LOOP]) begin
        can_rxd <= txd_q;
      end else begin
        can_rxd <= !bus_q;
      end
      low_line_termination <= !rx_path_on;
      high_line_termination <= 1'b1;
    end
  end

  // ----------------------------------------
  // Load switches
  // ----------------------------------------
  logic loads_on;
  logic hs1_drive;

  assign loads_on = (current_mode != MODE_CYCLIC);
  assign hs1_drive = ctl[`SBC_CTL_HS1] && (!ctl[`SBC_CTL_PWM_EN] || pwm_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_switch_one <= 1'b0;
      high_switch_two <= 1'b0;
      high_switch_three <= 1'b0;
      low_switch_one <= 1'b0;
      low_switch_two <= 1'b0;
    end else begin
      high_switch_one <= loads_on && hs1_drive;
      high_switch_two <= loads_on && ctl[`SBC_CTL_HS2];
      high_switch_three <= loads_on ? ctl[`SBC_CTL_HS3] : (cyclic_state == CYC_HS_ON);
      low_switch_one <= loads_on && ctl[`SBC_CTL_LS1];
      low_switch_two <= loads_on && ctl[`SBC_CTL_LS2];
    end
  end

  // ----------------------------------------
  // Reset output
  // ----------------------------------------
  logic [7:0] rst_cnt;
  logic rst_done;

  assign rst_done = (rst_cnt == 8'(`SBC_RESET_CLKS));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_cnt <= 8'h00;
      reset_out_n <= 1'b0;
      reset_out_oe_n <= 1'b0;
    end else begin
      if (!rst_done) begin
        rst_cnt <= 8'(rst_cnt + 8'h01);
      end
      reset_out_n <= 1'b0;
      reset_out_oe_n <= rst_done;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_out_released: assert property (!sel_q |=> serial_out_oe_n)
    else $error("serial output driven while deselected");
  a_out_next_bit: assert property (sel_q && sclk_rise && !sel_fall |=> serial_out == $past(tx_shift[1]))
    else $error("serial output did not advance on clock rise");
  a_first_bit: assert property (sel_fall |=> serial_out == $past(diag[0]) && !serial_out_oe_n)
    else $error("first diagnosis bit wrong");
  a_shift_in_lsb: assert property (sel_q && sclk_fall && !sel_fall |=> rx_shift[15] == $past(si_q))
    else $error("input bit not captured on clock fall");
  a_frame_length: assert property (word.push_valid |-> bit_cnt == 5'h10 && sel_rise)
    else $error("word pushed from wrong frame length");
  a_mode_decode: assert property (apply |=> current_mode == decode_mode($past(next_bits)))
    else $error("mode field decoded wrongly");
  a_tx_blocked: assert property (current_mode != MODE_NORMAL |=> !bus_drive_dominant)
    else $error("transmitter active outside normal mode");
  a_rx_loop: assert property (current_mode == MODE_RXONLY && ctl[`SBC_CTL_LOOP] |=> can_rxd == $past(txd_q))
    else $error("loop path not applied");
  a_term_supply: assert property (current_mode == MODE_RXONLY |=> !low_line_termination && high_line_termination)
    else $error("termination wrong in receive-only mode");
  a_hs3_off: assert property (cyclic_state == CYC_HS_OFF && current_mode == MODE_CYCLIC |=> !high_switch_three)
    else $error("third high output on in switch-off state");
  a_wake_edge: assert property (cyclic_state == CYC_HS_OFF && wake_rise && !apply |=> cyclic_state == CYC_HS_ON)
    else $error("wake edge ignored");
  a_reset_hold: assert property ($fell(rst_done) |-> 1'b0)
    else $error("reset counter restarted");
  a_reset_release: assert property (rst_cnt == 8'(`SBC_RESET_CLKS - 1) |=> !reset_out_oe_n ##1 reset_out_oe_n)
    else $error("reset output released at wrong time");

  c_word_applied: cover property (word.push_valid ##[1:8] apply);
  c_cyclic_off: cover property (cyclic_state == CYC_HS_ON ##1 cyclic_state == CYC_HS_OFF);
  c_timer_wake: cover property (timer_done);
  c_word_lost: cover property (word.push_valid && !word.push_ready);
endmodule // sbcmc_top

// ### common/sbcmc_params.svh
`ifndef SBCMC_PARAMS_SVH
`define SBCMC_PARAMS_SVH
// Notes on behaviour
// - Serial output released while select is high
// - Diagnosis word is 16 bits, LSB first
// - Output bits advance on serial clock rise
// - Input bits captured on serial clock fall
// - Transfer only while select is held low
// - Bits 10..9 select the operating mode
// - Cyclic wake splits into switch on/off
// - Normal mode transmits, receives, drives switches
// - Receive-only blocks transmitter, keeps receive path
// - Receive-only may loop transmit to receive
// - Receive-only terminations go to logic supply
// - Receive output low dominant, high recessive
// - Transmit low means dominant; undriven reads high
// - Wake rising edge wakes cyclic mode; default low
// - Pulse-width input switches first high output
// - Third high output follows cyclic timer
// - Low outputs and second high from serial
// - Reset is active-low open-drain output
// - Bits 13..12 select cyclic wake period
// - Bit 1 enables, bit 11 adds pulse gating

// ----------------------------------------
// Word layout
// ----------------------------------------
`define SBC_WORD_BITS 16
`define SBC_BUF_DEPTH 2
`define SBC_CTL_HS2 0
`define SBC_CTL_HS1 1
`define SBC_CTL_HS3 2
`define SBC_CTL_LS1 3
`define SBC_CTL_LS2 4
`define SBC_CTL_LOOP 5
`define SBC_CTL_MODE_LSB 9
`define SBC_CTL_PWM_EN 11
`define SBC_CTL_PER_LSB 12
`define SBC_CTL_RESET 16'h0000
`define SBC_MODE_NORMAL 2'h3
`define SBC_MODE_CYCLIC 2'h2
`define SBC_MODE_RXONLY 2'h1
`define SBC_DIAG_MODE_LSB 0
`define SBC_DIAG_HS_ON 2
`define SBC_DIAG_WAKE 3
`define SBC_DIAG_LOST 4
`define SBC_DIAG_RST_PIN 5
`define SBC_DIAG_PWM 6
`define SBC_DIAG_BUS 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define SBC_CLK_PERIOD_NS 25
`define SBC_OSC_PERIOD_NS 512000
`define SBC_OSC_TICK_CLKS (`SBC_OSC_PERIOD_NS / `SBC_CLK_PERIOD_NS)
`define SBC_PERIOD_0 9'h05E
`define SBC_PERIOD_1 9'h0BC
`define SBC_PERIOD_2 9'h178
`define SBC_RESET_HOLD_NS 1000
`define SBC_RESET_CLKS ((`SBC_RESET_HOLD_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_SYNC_RESET 8'h8A
`endif

// ### common/sbcmc_pkg.sv
`include "sbcmc_params.svh"
package sbcmc_pkg;
  typedef enum logic [1:0] {MODE_STANDBY, MODE_RXONLY, MODE_CYCLIC, MODE_NORMAL} sbcmc_mode_e;
  typedef enum logic [1:0] {CYC_IDLE, CYC_HS_ON, CYC_HS_OFF} sbcmc_cyc_e;
  typedef logic [`SBC_WORD_BITS-1:0] sbcmc_word_t;
endpackage

// ### common/sbcmc_word_if.sv
interface sbcmc_word_if;
  import sbcmc_pkg::*;
  logic push_valid;
  logic push_ready;
  sbcmc_word_t push_data;
  logic pop_valid;
  logic pop_ready;
  sbcmc_word_t pop_data;
  modport store (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface // sbcmc_word_if

// ### rtl/sbcmc_buf.sv
module sbcmc_buf (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Word stream
  sbcmc_word_if.store port
);
  import sbcmc_pkg::*;

  sbcmc_word_t mem [`SBC_BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign push = port.push_valid && port.push_ready;
  assign pop = port.pop_valid && port.pop_ready;
  assign port.push_ready = (count != 2'h2);
  assign port.pop_valid = (count != 2'h0);
  assign port.pop_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= port.push_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule // sbcmc_buf

// ### verification/sbcmc_master_model.sv
module sbcmc_master_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic serial_clk,
  output logic serial_select_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Serial clock stands low outside frames; data line has a pull-down
  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_in = 1'b0;
  end

  // --------------------------------
  // Half of the 200 ns serial period
  // --------------------------------
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // Bit count other than 16 is allowed so refused frames can be made
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] diag, output logic oe_bad);
    diag = 16'h0000;
    oe_bad = 1'b0;
    serial_select_n = 1'b0;
    half();
    half();
    for (int i = 0; i < nbits; i++) begin
      half();
      if (serial_out_oe_n !== 1'b0) oe_bad = 1'b1;
      // Sampled just before the rise, the bit is settled by then
      if (i < 16) diag[i] = serial_out;
      serial_clk = 1'b1;
      // Data moves with the rise so it is settled at the capturing fall
      serial_in = word[i % 16];
      half();
      serial_clk = 1'b0;
    end
    half();
    serial_select_n = 1'b1;
    serial_in = 1'b0;
    half();
    half();
  endtask
endmodule // sbcmc_master_model

// ### verification/sbcmc_top_tb.sv
module sbcmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbcmc_pkg::*;

  logic clk, rst, can_txd, bus_dominant, pwm_input, wake_input;
  wire serial_clk, serial_select_n, serial_in, serial_out, serial_out_oe_n;
  wire can_rxd, bus_drive_dominant, low_line_termination, high_line_termination;
  wire high_switch_one, high_switch_two, high_switch_three, low_switch_one, low_switch_two;
  wire reset_out_n, reset_out_oe_n, reset_out_n_i, word_lost;
  sbcmc_mode_e current_mode;
  sbcmc_cyc_e cyclic_state;
  int fail_count, n_checks;
  logic [31:0] seed, r;
  logic [15:0] ctl, d;
  logic bad;
  logic [1:0] modes [3] = '{2'h3, 2'h1, 2'h0};
  wire [15:0] outs = {6'h00, word_lost, bus_drive_dominant, can_rxd, low_line_termination,
    high_line_termination, high_switch_one, high_switch_two, high_switch_three, low_switch_one, low_switch_two};

  // Open-drain reset pin with pull-up
  assign reset_out_n_i = reset_out_oe_n ? 1'b1 : reset_out_n;

  sbcmc_top #(.OSC_TICK_CLKS(4)) u_sbcmc_top (.clk(clk), .rst(rst), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .can_txd(can_txd), .can_rxd(can_rxd), .bus_dominant(bus_dominant),
    .bus_drive_dominant(bus_drive_dominant), .low_line_termination(low_line_termination),
    .high_line_termination(high_line_termination), .pwm_input(pwm_input), .wake_input(wake_input),
    .high_switch_one(high_switch_one), .high_switch_two(high_switch_two), .high_switch_three(high_switch_three),
    .low_switch_one(low_switch_one), .low_switch_two(low_switch_two), .reset_out_n_i(reset_out_n_i),
    .reset_out_n(reset_out_n), .reset_out_oe_n(reset_out_oe_n), .current_mode(current_mode),
    .cyclic_state(cyclic_state), .word_lost(word_lost));

  sbcmc_master_model u_sbcmc_master_model (.clk(clk), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n));

  // --------------------------------
  // Reference model and helpers
  // --------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected pins outside cyclic wake
  function automatic logic [15:0] exp_out(logic [15:0] c, logic txd, logic bus, logic pwm);
    logic [1:0] m;
    logic [15:0] e;
    m = c[10:9];
    e = 16'h0000;
    e[8] = (m == 2'h3) ? !txd : 1'b0;
    e[7] = (m == 2'h1 && c[5]) ? txd : !bus;
    e[6] = !(m == 2'h3 || m == 2'h1);
    e[5] = 1'b1;
    e[4:0] = {c[1] & (!c[11] | pwm), c[0], c[2], c[3], c[4]};
    return e;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic send(input logic [15:0] w);
    u_sbcmc_master_model.xfer(w, 16, d, bad);
    chk({11'h000, d[7:5], d[1:0]}, {11'h000, bus_dominant, pwm_input, 1'b1, ctl[10:9]});
    chk({15'h0000, bad}, 16'h0000);
    ctl = w;
    repeat (12) @(negedge clk);
    chk({14'h0000, current_mode}, {14'h0000, w[10:9]});
    chk({15'h0000, serial_out_oe_n}, 16'h0001);
    if (w[10:9] != 2'h2) chk(outs, exp_out(w, can_txd, bus_dominant, pwm_input));
  endtask

  // Random pin levels, then compare with the model
  task automatic stir();
    r = rnd();
    can_txd = r[0];
    bus_dominant = r[1];
    pwm_input = r[2];
    repeat (8) @(negedge clk);
    chk(outs, exp_out(ctl, can_txd, bus_dominant, pwm_input));
  endtask

  task automatic bad_frame(input int n);
    r = rnd();
    u_sbcmc_master_model.xfer(r[15:0], n, d, bad);
    repeat (12) @(negedge clk);
    chk(outs, exp_out(ctl, can_txd, bus_dominant, pwm_input));
  endtask

  task automatic cyc_chk(input sbcmc_cyc_e s, input logic hs3);
    chk({9'h000, cyclic_state, outs[4:0]}, {9'h000, s, 2'b00, hs3, 2'b00});
  endtask

  // --------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #400000;
    fail_count++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    can_txd = 1'b1;
    bus_dominant = 1'b0;
    pwm_input = 1'b0;
    wake_input = 1'b0;
    seed = 32'h3a1f_a8e1;
    ctl = 16'h0000;
    fail_count = 0;
    n_checks = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (39) @(negedge clk);
    chk({14'h0000, reset_out_oe_n, reset_out_n}, 16'h0000);
    chk(outs, exp_out(ctl, 1'b1, 1'b0, 1'b0));
    repeat (4) @(negedge clk);
    chk({14'h0000, reset_out_oe_n, reset_out_n}, 16'h0002);
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      send({4'h0, r[11], modes[k % 3], 3'b000, r[5:0]});
      stir();
      stir();
    end
    bad_frame(15);
    bad_frame(17);
    // Cyclic wake: timer with the shortest period, then the wake pin
    pwm_input = 1'b0;
    bus_dominant = 1'b0;
    send(16'h0400);
    cyc_chk(CYC_HS_ON, 1'b1);
    pwm_input = 1'b1;
    repeat (365) @(negedge clk);
    cyc_chk(CYC_HS_OFF, 1'b0);
    repeat (30) @(negedge clk);
    cyc_chk(CYC_HS_ON, 1'b1);
    pwm_input = 1'b0;
    repeat (8) @(negedge clk);
    pwm_input = 1'b1;
    repeat (8) @(negedge clk);
    cyc_chk(CYC_HS_OFF, 1'b0);
    wake_input = 1'b1;
    repeat (8) @(negedge clk);
    cyc_chk(CYC_HS_ON, 1'b1);
    wake_input = 1'b0;
    pwm_input = 1'b0;
    // No timed wake-up with both period bits set
    send(16'h3400);
    pwm_input = 1'b1;
    repeat (1600) @(negedge clk);
    cyc_chk(CYC_HS_OFF, 1'b0);
    send(16'h061f);
    stir();
    summarize();
  end
endmodule // sbcmc_top_tb
